// ---- rtl/anbp_base_page_regs.v ----
// Advertisement and partner ability registers of the auto-negotiation base page
`timescale 1ns/1ps
`default_nettype none
`include "anbp_defines.vh"

// Overview of operation
// - Writable 16-bit advertisement register sits at management index 4.
// - Advertisement bit 15 is read/write next-page capability, reset 0.
// - Advertisement bit 13 advertises remote fault indication, read/write, reset 0.
// - Advertisement bit 11 is read/write asymmetric pause, reset 1.
// - Advertisement bit 10 is read/write symmetric pause, reset 1.
// - Advertisement bits 8..5 are 100 FD, 100 HD, 10 FD, 10 HD flags.
// - Those four speed/duplex bits reset from the sampled strap inputs.
// - Advertisement bits 4:0 are selector, read/write, reset 00001.
// - Read-only partner ability register at index 5, all fields reset 0.
// - Partner bit 15 shows next page, bit 12 extended next page.
// - Partner bit 14 reads 1 once the partner code word arrived.
// - Partner bit 13 reports the partner's remote fault.
// - Partner bits 11 and 10 report asymmetric and symmetric pause.
// - Partner bits 9..5 report T4, 100 FD, 100 HD, 10 FD, 10 HD.
// - Partner bits 4:0 hold received selector, reset 00000.
module anbp_base_page_regs #(
  parameter integer STRAP_W = 4
) (
  input  wire                   clk,
  input  wire                   rstn,
  input  wire [STRAP_W-1:0]     modeStrap,
  input  wire [`ANBP_IDX_W-1:0] regIndex,
  input  wire                   regWrEn,
  input  wire [15:0]            regWrData,
  input  wire                   regRdEn,
  output reg  [15:0]            regRdData_r,
  output reg                    regRdValid_r,
  output reg  [15:0]            txBasePage_r,
  output wire [15:0]            partnerAbility,
  input  wire                   rxPageValid,
  input  wire [15:0]            rxPageWord,
  input  wire                   negRestart
);

  // ***********************************************************
  // Index decode
  // ***********************************************************
  function isIndex;
    input [`ANBP_IDX_W-1:0] idx;
    input [`ANBP_IDX_W-1:0] target;
    begin
      isIndex = (idx == target);
    end
  endfunction

  // ***********************************************************
  // Strap capture
  // ***********************************************************
  wire [STRAP_W-1:0] strapValue;
  wire               strapLoad;

  anbp_strap_capture #(
    .STRAP_W (STRAP_W)
  ) u_strap (
    .clk          (clk),
    .rstn         (rstn),
    .strapPins    (modeStrap),
    .strapValue_r (strapValue),
    .strapLoad_r  (strapLoad)
  );

  // ***********************************************************
  // Partner ability register
  // ***********************************************************
  wire [15:0] partnerWord;

  anbp_partner_latch u_partner (
    .clk           (clk),
    .rstn          (rstn),
    .rxPageValid   (rxPageValid),
    .rxPageWord    (rxPageWord),
    .negRestart    (negRestart),
    .partnerWord_r (partnerWord)
  );

  assign partnerAbility = partnerWord;

  // ***********************************************************
  // Advertisement register
  // ***********************************************************
  reg  [15:0] adv_nxt;
  wire        advWrite = regWrEn && isIndex(regIndex, `ANBP_IDX_ADVERTISE);

  always @* begin
    adv_nxt = txBasePage_r;
    if (strapLoad) begin
      adv_nxt[`ANBP_SPEED_MSB:`ANBP_SPEED_LSB] = strapValue;
    end
    if (advWrite) begin
      adv_nxt = regWrData & `ANBP_ADV_WR_MASK;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      txBasePage_r <= `ANBP_ADV_RST_FIXED;
    end else begin
      txBasePage_r <= adv_nxt;
    end
  end

  // ***********************************************************
  // Read port, one cycle latency; other indices read zero
  // ***********************************************************
  always @(posedge clk) begin
    if (!rstn) begin
      regRdData_r  <= 16'h0000;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRdEn;
      if (regRdEn) begin
        if (isIndex(regIndex, `ANBP_IDX_ADVERTISE)) begin
          regRdData_r <= txBasePage_r & `ANBP_ADV_WR_MASK;
        end else if (isIndex(regIndex, `ANBP_IDX_PARTNER)) begin
          regRdData_r <= partnerWord;
        end else begin
          regRdData_r <= 16'h0000;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/anbp_defines.vh ----
// Register indices, field positions and reset values of the base page registers
`ifndef ANBP_DEFINES_VH
`define ANBP_DEFINES_VH

// ***********************************************************
// Management indices
// ***********************************************************
`define ANBP_IDX_W          5
`define ANBP_IDX_ADVERTISE  5'h04
`define ANBP_IDX_PARTNER    5'h05

// ***********************************************************
// Field positions, shared by both registers
// ***********************************************************
`define ANBP_BIT_NEXT_PAGE  15
`define ANBP_BIT_ACK        14
`define ANBP_BIT_RFAULT     13
`define ANBP_BIT_EXT_NP     12
`define ANBP_BIT_PAUSE_ASYM 11
`define ANBP_BIT_PAUSE_SYM  10
`define ANBP_BIT_T4         9
`define ANBP_BIT_TX_FD      8
`define ANBP_BIT_TX_HD      7
`define ANBP_BIT_10_FD      6
`define ANBP_BIT_10_HD      5
`define ANBP_SPEED_MSB      8
`define ANBP_SPEED_LSB      5
`define ANBP_SEL_MSB        4
`define ANBP_SEL_LSB        0

// ***********************************************************
// Reset values and write masks
// ***********************************************************
`define ANBP_ADV_RST_FIXED  16'h0c01
`define ANBP_ADV_WR_MASK    16'hbfff
`define ANBP_PTNR_RST       16'h0000
`define ANBP_SEL_IEEE8023   5'h01

`endif

// ---- rtl/anbp_partner_latch.v ----
// Holds the base page received from the link partner
`timescale 1ns/1ps
`default_nettype none
`include "anbp_defines.vh"

module anbp_partner_latch (
  input  wire        clk,
  input  wire        rstn,
  input  wire        rxPageValid,
  input  wire [15:0] rxPageWord,
  input  wire        negRestart,
  output reg  [15:0] partnerWord_r
);

  // ***********************************************************
  // Page latch; a page arriving with a restart is kept
  // ***********************************************************
  always @(posedge clk) begin
    if (!rstn) begin
      partnerWord_r <= `ANBP_PTNR_RST;
    end else if (rxPageValid) begin
      partnerWord_r <= rxPageWord;
      partnerWord_r[`ANBP_BIT_ACK] <= 1'b1;
    end else if (negRestart) begin
      partnerWord_r <= `ANBP_PTNR_RST;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/anbp_strap_capture.v ----
// Strap synchroniser and one-shot capture after reset release
`timescale 1ns/1ps
`default_nettype none

module anbp_strap_capture #(
  parameter integer STRAP_W = 4
) (
  input  wire               clk,
  input  wire               rstn,
  input  wire [STRAP_W-1:0] strapPins,
  output reg  [STRAP_W-1:0] strapValue_r,
  output reg                strapLoad_r
);

  // ***********************************************************
  // Two-flop synchroniser, free running
  // ***********************************************************
  reg [STRAP_W-1:0] strapMeta_r;
  reg [STRAP_W-1:0] strapSync_r;
  reg               captured_r;

  always @(posedge clk) begin
    strapMeta_r <= strapPins;
    strapSync_r <= strapMeta_r;
  end

  // ***********************************************************
  // Capture once, at the first edge after reset release
  // ***********************************************************
  always @(posedge clk) begin
    if (!rstn) begin
      captured_r   <= 1'b0;
      strapLoad_r  <= 1'b0;
      strapValue_r <= {STRAP_W{1'b0}};
    end else begin
      strapLoad_r <= 1'b0;
      if (!captured_r) begin
        captured_r   <= 1'b1;
        strapLoad_r  <= 1'b1;
        strapValue_r <= strapSync_r;
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/anbp_checker_properties.sv ----
// Concurrent checks on the base page register ports
`timescale 1ns/1ps
`default_nettype none
module anbp_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic        regRdValid_r,
  input wire logic        rxPageValid,
  input wire logic        negRestart,
  input wire logic [4:0]  regIndex,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData_r,
  input wire logic [15:0] txBasePage_r,
  input wire logic [15:0] partnerAbility,
  input wire logic [15:0] rxPageWord
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd; regRdEn |=> regRdValid_r; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_norv; !regRdEn |=> !regRdValid_r; endproperty
  a_norv: assert property (p_norv) else $error("stray read valid");
  property p_rdadv; regRdEn && regIndex == 5'h04 |=> regRdData_r == $past(txBasePage_r);
  endproperty
  a_rdadv: assert property (p_rdadv) else $error("bad advert read");
  property p_rdptn; regRdEn && regIndex == 5'h05 |=> regRdData_r == $past(partnerAbility);
  endproperty
  a_rdptn: assert property (p_rdptn) else $error("bad partner read");
  property p_rdnone; regRdEn && regIndex != 5'h04 && regIndex != 5'h05 |=> regRdData_r == 16'h0000;
  endproperty
  a_rdnone: assert property (p_rdnone) else $error("unmapped read nonzero");
  property p_wr; regWrEn && regIndex == 5'h04 |=> txBasePage_r == ($past(regWrData) & 16'hbfff);
  endproperty
  a_wr: assert property (p_wr) else $error("advert write lost");
  property p_rsv; txBasePage_r[14] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_rx; rxPageValid |=> partnerAbility == ($past(rxPageWord) | 16'h4000); endproperty
  a_rx: assert property (p_rx) else $error("page not latched");
  property p_clr; negRestart && !rxPageValid |=> partnerAbility == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("restart did not clear");
  property p_hold; !rxPageValid && !negRestart |=> $stable(partnerAbility); endproperty
  a_hold: assert property (p_hold) else $error("partner word changed");
endmodule
bind anbp_base_page_regs anbp_checker i_chk (.clk(clk), .rstn(rstn), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdValid_r(regRdValid_r), .rxPageValid(rxPageValid),
  .negRestart(negRestart), .regIndex(regIndex), .regWrData(regWrData),
  .regRdData_r(regRdData_r), .txBasePage_r(txBasePage_r), .partnerAbility(partnerAbility),
  .rxPageWord(rxPageWord));
`default_nettype wire

// ---- tb/anbp_link_partner.sv ----
// Link partner model delivering received base pages
`timescale 1ns/1ps
`default_nettype none
module anbp_link_partner (
  input  wire logic        clk,
  output var  logic        rxPageValid = 1'b0,
  output var  logic [15:0] rxPageWord = 16'h0000
);
  logic        pend = 1'b0;
  logic [15:0] pw = 16'h0000;
  // Word toggles between pages so a stale word never matches
  always @(posedge clk) begin
    rxPageValid <= pend;
    rxPageWord <= pend ? pw : ~rxPageWord;
  end
  task automatic send(input logic [15:0] w);
    pw = w;
    pend = 1'b1;
    @(posedge clk);
    #1;
    pend = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the base page register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0, negRestart = 0;
  logic        regRdValid_r, rxPageValid;
  logic [3:0]  modeStrap = 4'h0;
  logic [4:0]  regIndex = 5'h00;
  logic [15:0] regWrData = 16'h0000, regRdData_r, txBasePage_r, partnerAbility, rxPageWord;
  logic [31:0] seed = 32'h690d;
  int          errors = 0, compares = 0, adv, ptn;
  always #2 clk = ~clk;
  anbp_base_page_regs #(.STRAP_W(4)) i_dut (.clk(clk), .rstn(rstn), .modeStrap(modeStrap),
    .regIndex(regIndex), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r), .txBasePage_r(txBasePage_r),
    .partnerAbility(partnerAbility), .rxPageValid(rxPageValid), .rxPageWord(rxPageWord),
    .negRestart(negRestart));
  anbp_link_partner i_lp (.clk(clk), .rxPageValid(rxPageValid), .rxPageWord(rxPageWord));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    {regWrEn, regRdEn, regIndex, regWrData} <= {w, !w, i, d};
    @(posedge clk);
    {regWrEn, regRdEn} <= 2'b00;
    #1;
  endtask
  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    acc(1'b0, i, 16'h0000);
    chk(regRdValid_r === 1'b1 ? regRdData_r : 16'hxxxx, e);
  endtask
  initial begin
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      rstn <= 1'b0;
      modeStrap <= r ? 4'h5 : 4'ha;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      adv = 16'h0c01 | ((r ? 4'h5 : 4'ha) << 5);
      chk(txBasePage_r, adv[15:0]);
      rd(5'h04, adv[15:0]);
      rd(5'h05, 16'h0000);
      ptn = 0;
      repeat (8) begin
        seed = lfsr(seed);
        modeStrap <= seed[7:4];
        adv = seed[15:0] & 16'hedff;
        acc(1'b1, 5'h04, adv[15:0]);
        adv = adv & 16'hbfff;
        chk(txBasePage_r, adv[15:0]);
        acc(1'b1, 5'h05, ~seed[15:0]);
        rd(5'h04, adv[15:0]);
        rd(5'h05, ptn[15:0]);
        i_lp.send({seed[7:0], seed[15:8]});
        ptn = {seed[7:0], seed[15:8]} | 16'h4000;
        rd(5'h05, ptn[15:0]);
        chk(partnerAbility, ptn[15:0]);
        rd(5'h06 | seed[20:16], 16'h0000);
      end
      @(posedge clk);
      negRestart <= 1'b1;
      @(posedge clk);
      negRestart <= 1'b0;
      rd(5'h05, 16'h0000);
    end
    wrap_up();
  end
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
